// >>> hdl/ebcp_phaser.sv
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ebcp_phaser (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [7:0]                   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output var  logic [31:0]                  wb_dat_o,
  output var  logic                         wb_ack_o,
  // External bus pins
  output var  logic [ebcp_pkg::ADDR_W-1:0]  address_bus_o,
  output var  logic [ebcp_pkg::DATA_W-1:0]  shared_addr_data_bus_o,
  output var  logic                         shared_addr_data_bus_oe_n_o,
  input  wire logic [ebcp_pkg::DATA_W-1:0]  shared_addr_data_bus_i,
  output var  logic [ebcp_pkg::DATA_W-1:0]  data_bus_o,
  output var  logic                         data_bus_oe_n_o,
  input  wire logic [ebcp_pkg::DATA_W-1:0]  data_bus_i,
  output var  logic                         addr_latch_o,
  output var  logic                         rd_n_o,
  output var  logic                         wr_n_o,
  output var  logic                         high_byte_enable_n_o,
  output var  logic [ebcp_pkg::NUM_CS-1:0]  cs_n_o,
  input  wire logic                         ready_i,
  output var  logic                         reference_clock_out_o
);

  localparam int unsigned NCS = ebcp_pkg::NUM_CS;
  localparam int unsigned AW  = ebcp_pkg::ADDR_W;
  localparam int unsigned DW  = ebcp_pkg::DATA_W;
  localparam int unsigned UW  = ebcp_pkg::UNIT_W;

  typedef struct packed {
    ebcp_pkg::ebcp_state_t  state;
    ebcp_pkg::ebcp_req_t    req;
    ebcp_pkg::ebcp_tcfg_t   [NCS-1:0] tcfg;
    ebcp_pkg::ebcp_tcfg_t   cur;
    logic [UW-1:0]          unit_div;
    logic [UW-1:0]          unit_cnt;
    logic [5:0]             ph_cnt;
    logic                   have_win;
    logic [7:0]             last_win;
    logic [DW-1:0]          rdata;
    logic                   busy;
    logic                   done;
    logic                   ack;
    logic [31:0]            dat;
    logic [AW-1:0]          a_pin;
    logic [DW-1:0]          ad_pin;
    logic                   ad_oe_n;
    logic [DW-1:0]          d_pin;
    logic                   d_oe_n;
    logic                   ale;
    logic                   rd_n;
    logic                   wr_n;
    logic                   hbe_n;
    logic [NCS-1:0]         cs_n;
    logic                   refclk;
  } ebcp_st_t;

  ebcp_st_t st_ff;
  ebcp_st_t nxt_st;

  logic [DW-1:0] ad_s;
  logic [DW-1:0] d_s;
  logic          rdy_s;
  logic          rdy_a;

  // Data pins are timed to the unit and come from outside, so they are synchronised.
  ebcp_sync #(.W(2 * DW)) u_dsync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({shared_addr_data_bus_i, data_bus_i}),
    .q_o   ({ad_s, d_s})
  );

  // The asynchronous path adds two more stages, costing at least one wait state.
  ebcp_sync #(.W(1)) u_rsync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (ready_i),
    .q_o   (rdy_s)
  );

  ebcp_sync #(.W(1)) u_rasync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (rdy_s),
    .q_o   (rdy_a)
  );

  logic tick;
  logic rdy_seen;
  logic [1:0] sel_cs;
  ebcp_pkg::ebcp_tcfg_t rd_cfg;

  always_comb
  begin
    nxt_st   = st_ff;
    tick     = (st_ff.unit_cnt == st_ff.unit_div);
    rdy_seen = (st_ff.cur.rdy_async ? rdy_a : rdy_s) ^ ~st_ff.cur.rdy_pol;
    sel_cs   = st_ff.req.cs;
    rd_cfg   = st_ff.tcfg[wb_adr_i[3:2]];
    nxt_st.ack  = 1'b0;
    nxt_st.done = 1'b0;
    nxt_st.refclk = ~st_ff.refclk;
    nxt_st.unit_cnt = tick ? '0 : st_ff.unit_cnt + 1'b1;

    // Wishbone slave; ack one cycle after the strobe, then dropped.
    if (wb_cyc_i && wb_stb_i && !st_ff.ack)
    begin
      nxt_st.ack = 1'b1;
      nxt_st.dat = 32'h0000_0000;
      if (wb_adr_i == ebcp_pkg::OFS_CTRL)
      begin
        nxt_st.dat = {31'h0000_0000, st_ff.busy};
        if (wb_we_i && wb_sel_i[0] && wb_dat_i[ebcp_pkg::CTRL_GO] && !st_ff.busy)
        begin
          nxt_st.req.write = wb_dat_i[ebcp_pkg::CTRL_WRITE];
          nxt_st.req.cs    = wb_dat_i[ebcp_pkg::CTRL_CS_LO +: 2];
          nxt_st.req.hbe_n = ~wb_dat_i[ebcp_pkg::CTRL_HBE];
          nxt_st.busy      = 1'b1;
        end
      end
      else if (wb_adr_i == ebcp_pkg::OFS_ADDR)
      begin
        nxt_st.dat = {8'h00, st_ff.req.addr};
        if (wb_we_i && !st_ff.busy)
        begin
          nxt_st.req.addr = wb_dat_i[AW-1:0];
        end
      end
      else if (wb_adr_i == ebcp_pkg::OFS_WDATA)
      begin
        nxt_st.dat = {16'h0000, st_ff.req.wdata};
        if (wb_we_i && !st_ff.busy)
        begin
          nxt_st.req.wdata = wb_dat_i[DW-1:0];
        end
      end
      else if (wb_adr_i == ebcp_pkg::OFS_RDATA)
      begin
        nxt_st.dat = {16'h0000, st_ff.rdata};
      end
      else if (wb_adr_i == ebcp_pkg::OFS_STATUS)
      begin
        nxt_st.dat = {26'h0000000, st_ff.state};
      end
      else if (wb_adr_i == ebcp_pkg::OFS_UNIT)
      begin
        nxt_st.dat = {28'h0000000, st_ff.unit_div};
        if (wb_we_i && !st_ff.busy)
        begin
          nxt_st.unit_div = wb_dat_i[UW-1:0];
        end
      end
      else if (wb_adr_i[7:4] == 4'h2 && wb_adr_i[1:0] == 2'h0
               && {1'b0, wb_adr_i[3:2]} < 3'(NCS))
      begin
        nxt_st.dat = {12'h000, rd_cfg.multiplexed_mode, rd_cfg.rdy_pol, rd_cfg.rdy_async, rd_cfg.rdy_en,
                      rd_cfg.f, 1'b0, rd_cfg.e, 1'b0, rd_cfg.d, rd_cfg.c, rd_cfg.abx, rd_cfg.ab};
        if (wb_we_i && !st_ff.busy)
        begin
          nxt_st.tcfg[wb_adr_i[3:2]] = {wb_dat_i[ebcp_pkg::TC_AB_LO +: 2],
            wb_dat_i[ebcp_pkg::TC_ABX_LO +: 2], wb_dat_i[ebcp_pkg::TC_C_LO +: 2],
            wb_dat_i[ebcp_pkg::TC_D], wb_dat_i[ebcp_pkg::TC_E_LO +: 5],
            wb_dat_i[ebcp_pkg::TC_F_LO +: 2], wb_dat_i[ebcp_pkg::TC_RDY_EN],
            wb_dat_i[ebcp_pkg::TC_RDY_ASYN], wb_dat_i[ebcp_pkg::TC_RDY_POL],
            wb_dat_i[ebcp_pkg::TC_MUX]};
        end
      end
    end

    case (st_ff.state)
      ebcp_pkg::EBCP_IDLE:
      begin
        nxt_st.cs_n    = '1;
        nxt_st.ad_oe_n = 1'b1;
        nxt_st.d_oe_n  = 1'b1;
        if (st_ff.busy && tick)
        begin
          nxt_st.cur   = st_ff.tcfg[sel_cs];
          // Longer setup only when the address window moves or no window has been set yet.
          nxt_st.ph_cnt = {4'h0, st_ff.tcfg[sel_cs].ab[0] ? 2'h1 : 2'h0}
            + ((!st_ff.have_win || st_ff.last_win != st_ff.req.addr[AW-1 -: 8])
               ? {4'h0, st_ff.tcfg[sel_cs].abx} : 6'h00);
          nxt_st.have_win = 1'b1;
          nxt_st.last_win = st_ff.req.addr[AW-1 -: 8];
          nxt_st.a_pin  = st_ff.req.addr;
          nxt_st.hbe_n  = st_ff.req.hbe_n;
          nxt_st.cs_n   = ~(NCS'(1) << sel_cs);
          nxt_st.ale    = st_ff.tcfg[sel_cs].multiplexed_mode;
          nxt_st.ad_pin = st_ff.req.addr[DW-1:0];
          nxt_st.ad_oe_n = ~st_ff.tcfg[sel_cs].multiplexed_mode;
          nxt_st.state  = ebcp_pkg::EBCP_AB;
        end
      end
      ebcp_pkg::EBCP_AB:
      begin
        if (tick)
        begin
          if (st_ff.ph_cnt == 6'h00)
          begin
            nxt_st.ale    = 1'b0;
            nxt_st.ph_cnt = {4'h0, st_ff.cur.c};
            nxt_st.state  = ebcp_pkg::EBCP_C;
          end
          else
          begin
            nxt_st.ph_cnt = st_ff.ph_cnt - 6'h01;
          end
        end
      end
      ebcp_pkg::EBCP_C:
      begin
        if (tick)
        begin
          if (st_ff.ph_cnt == 6'h00)
          begin
            // Shared lines carry write data only for a multiplexed write, else released.
            nxt_st.ad_oe_n = ~(st_ff.cur.multiplexed_mode && st_ff.req.write);
            nxt_st.ad_pin  = st_ff.req.wdata;
            nxt_st.d_oe_n  = ~(!st_ff.cur.multiplexed_mode && st_ff.req.write);
            nxt_st.d_pin   = st_ff.req.wdata;
            nxt_st.ph_cnt  = {5'h00, st_ff.cur.d};
            nxt_st.state   = ebcp_pkg::EBCP_D;
          end
          else
          begin
            nxt_st.ph_cnt = st_ff.ph_cnt - 6'h01;
          end
        end
      end
      ebcp_pkg::EBCP_D:
      begin
        if (tick)
        begin
          if (st_ff.ph_cnt == 6'h00)
          begin
            nxt_st.rd_n   = st_ff.req.write;
            nxt_st.wr_n   = ~st_ff.req.write;
            nxt_st.ph_cnt = {1'b0, st_ff.cur.e};
            nxt_st.state  = ebcp_pkg::EBCP_E;
          end
          else
          begin
            nxt_st.ph_cnt = st_ff.ph_cnt - 6'h01;
          end
        end
      end
      ebcp_pkg::EBCP_E:
      begin
        if (tick)
        begin
          if (st_ff.ph_cnt != 6'h00)
          begin
            nxt_st.ph_cnt = st_ff.ph_cnt - 6'h01;
          end
          else if (!st_ff.cur.rdy_en || rdy_seen)
          begin
            // Read data is taken on the strobe's closing edge, from the shared lines in multiplexed mode, else the data pins.
            if (!st_ff.req.write)
            begin
              nxt_st.rdata = st_ff.cur.multiplexed_mode ? ad_s : d_s;
            end
            nxt_st.rd_n   = 1'b1;
            nxt_st.wr_n   = 1'b1;
            nxt_st.a_pin  = st_ff.req.addr + AW'(1);
            nxt_st.ph_cnt = {4'h0, st_ff.cur.f};
            nxt_st.state  = ebcp_pkg::EBCP_F;
          end
        end
      end
      ebcp_pkg::EBCP_F:
      begin
        if (tick)
        begin
          if (st_ff.ph_cnt == 6'h00)
          begin
            nxt_st.cs_n    = '1;
            nxt_st.ad_oe_n = 1'b1;
            nxt_st.d_oe_n  = 1'b1;
            nxt_st.busy    = 1'b0;
            nxt_st.done    = 1'b1;
            nxt_st.state   = ebcp_pkg::EBCP_IDLE;
          end
          else
          begin
            nxt_st.ph_cnt = st_ff.ph_cnt - 6'h01;
          end
        end
      end
      default:
      begin
        nxt_st.state = ebcp_pkg::EBCP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff          <= '0;
      st_ff.state    <= ebcp_pkg::EBCP_IDLE;
      st_ff.unit_div <= ebcp_pkg::UNIT_RST;
      st_ff.ad_oe_n  <= 1'b1;
      st_ff.d_oe_n   <= 1'b1;
      st_ff.rd_n     <= 1'b1;
      st_ff.wr_n     <= 1'b1;
      st_ff.hbe_n    <= 1'b1;
      st_ff.cs_n     <= '1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o                    = st_ff.dat;
  assign wb_ack_o                    = st_ff.ack;
  assign address_bus_o               = st_ff.a_pin;
  assign shared_addr_data_bus_o      = st_ff.ad_pin;
  assign shared_addr_data_bus_oe_n_o = st_ff.ad_oe_n;
  assign data_bus_o                  = st_ff.d_pin;
  assign data_bus_oe_n_o             = st_ff.d_oe_n;
  assign addr_latch_o                = st_ff.ale;
  assign rd_n_o                      = st_ff.rd_n;
  assign wr_n_o                      = st_ff.wr_n;
  assign high_byte_enable_n_o        = st_ff.hbe_n;
  assign cs_n_o                      = st_ff.cs_n;
  assign reference_clock_out_o       = st_ff.refclk;

endmodule : ebcp_phaser
`default_nettype wire

// >>> hdl/ebcp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ebcp_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ebcp_sync_t;

  ebcp_sync_t st_ff;
  ebcp_sync_t nxt_st;

  always_comb
  begin
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.s2;

endmodule : ebcp_sync
`default_nettype wire

// >>> inc/ebcp_pkg.sv
package ebcp_pkg;

  localparam int unsigned NUM_CS   = 4;
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned UNIT_W   = 4;

  // Wishbone register map, byte addresses.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ADDR    = 8'h04;
  localparam logic [7:0] OFS_WDATA   = 8'h08;
  localparam logic [7:0] OFS_RDATA   = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_UNIT    = 8'h14;
  localparam logic [7:0] OFS_TCFG0   = 8'h20;

  // CTRL fields: write with GO bit starts a cycle.
  localparam int unsigned CTRL_GO     = 0;
  localparam int unsigned CTRL_WRITE  = 1;
  localparam int unsigned CTRL_CS_LO  = 4;
  localparam int unsigned CTRL_HBE    = 8;

  // Timing configuration fields per chip select.
  localparam int unsigned TC_AB_LO    = 0;
  localparam int unsigned TC_ABX_LO   = 2;
  localparam int unsigned TC_C_LO     = 4;
  localparam int unsigned TC_D        = 6;
  localparam int unsigned TC_E_LO     = 8;
  localparam int unsigned TC_F_LO     = 14;
  localparam int unsigned TC_RDY_EN   = 16;
  localparam int unsigned TC_RDY_ASYN = 17;
  localparam int unsigned TC_RDY_POL  = 18;
  localparam int unsigned TC_MUX      = 19;

  localparam logic [31:0]       TCFG_RST   = 32'h0000_0000;
  localparam logic [UNIT_W-1:0] UNIT_RST   = 4'h0;
  localparam logic [2:0]        AB_MAX_EXT = 3'h5;

  typedef enum logic [5:0] {
    EBCP_IDLE = 6'b000001,
    EBCP_AB   = 6'b000010,
    EBCP_C    = 6'b000100,
    EBCP_D    = 6'b001000,
    EBCP_E    = 6'b010000,
    EBCP_F    = 6'b100000
  } ebcp_state_t;

  typedef struct packed {
    logic [1:0] ab;
    logic [1:0] abx;
    logic [1:0] c;
    logic       d;
    logic [4:0] e;
    logic [1:0] f;
    logic       rdy_en;
    logic       rdy_async;
    logic       rdy_pol;
    logic       multiplexed_mode;
  } ebcp_tcfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
    logic [1:0]        cs;
    logic              hbe_n;
  } ebcp_req_t;

endpackage : ebcp_pkg

// >>> verif/ebcp_ext_model.sv
`timescale 1ns/10ps
`default_nettype none
module ebcp_ext_model (
  // Clock and controller pins
  input  wire logic        clk_i,
  input  wire logic [3:0]  cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        addr_latch_i,
  input  wire logic [15:0] sad_i,
  input  wire logic [15:0] dat_i,
  input  wire logic        dat_oe_n_i,
  // Behaviour and observations
  input  wire logic [15:0] rd_val_i,
  input  wire logic [7:0]  rdy_wait_i,
  output var  logic [15:0] bus_o,
  output var  logic        ready_o,
  output var  logic [15:0] lat_o,
  output var  logic [15:0] wd_o,
  output var  logic [3:0]  cs_o,
  output var  logic [15:0] lo_o,
  output var  logic [15:0] su_o
);
  logic        got = 1'b0;
  logic [15:0] lo  = 16'h0000;
  logic [15:0] su  = 16'h0000;
  wire         strb = !rd_n_i || !wr_n_i;
  initial
  begin
    bus_o   = 16'h0000;
    ready_o = 1'b0;
  end
  always @(posedge clk_i)
  begin
    if (addr_latch_i)
    begin
      lat_o <= sad_i;
    end
    if (&cs_n_i)
    begin
      su  <= 16'h0000;
      got <= 1'b0;
    end
    else if (!strb && !got)
    begin
      su <= su + 16'h0001;
    end
    if (strb)
    begin
      lo      <= lo + 16'h0001;
      ready_o <= lo >= {8'h00, rdy_wait_i};
      if (!got)
      begin
        su_o  <= su;
        cs_o  <= cs_n_i;
        bus_o <= rd_val_i;
        got   <= 1'b1;
      end
      if (!wr_n_i)
      begin
        wd_o <= dat_oe_n_i ? sad_i : dat_i;
      end
    end
    else
    begin
      if (lo != 16'h0000)
      begin
        lo_o <= lo;
      end
      lo      <= 16'h0000;
      ready_o <= 1'b0;
      // Released lines keep moving, so stale data cannot pass for a good capture.
      bus_o   <= ~bus_o;
    end
  end
endmodule : ebcp_ext_model
`default_nettype wire

// >>> verif/ebcp_phaser_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ebcp_phaser_bench;
  localparam int CPU = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q, rt [5];
  logic        wb_ack_o, sad_oe_n, dat_oe_n, ale, rd_n, wr_n, ready, hbe_n;
  logic        hbe_on = 1'b0;
  logic [23:0] address_bus_o, ra [5];
  logic [15:0] sad_o, dat_o, bus, lat, wd, lo, su, sub, lob;
  logic [15:0] rd_val = 16'h5AC3;
  logic [7:0]  rdy_wait = 8'h14;
  logic [3:0]  cs_n, cs_seen;
  wire  [15:0] sad_i = sad_oe_n ? bus : sad_o;
  wire  [15:0] dat_i = dat_oe_n ? bus : dat_o;
  int          rs [5] = '{3, 1, 1, 0, 3};
  int          rl [5] = '{0, 0, 0, 31, 0};
  int          fails = 0;
  int          num_checks = 0;
  always #2.5 clk_i = ~clk_i;
  ebcp_phaser u_ebcp_phaser (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .address_bus_o,
    .shared_addr_data_bus_o(sad_o), .shared_addr_data_bus_oe_n_o(sad_oe_n),
    .shared_addr_data_bus_i(sad_i), .data_bus_o(dat_o), .data_bus_oe_n_o(dat_oe_n),
    .data_bus_i(dat_i), .addr_latch_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .high_byte_enable_n_o(hbe_n), .cs_n_o(cs_n), .ready_i(ready), .reference_clock_out_o());
  ebcp_ext_model u_ebcp_ext_model (.clk_i, .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .addr_latch_i(ale), .sad_i(sad_o), .dat_i(dat_o), .dat_oe_n_i(dat_oe_n),
    .rd_val_i(rd_val), .rdy_wait_i(rdy_wait), .bus_o(bus), .ready_o(ready), .lat_o(lat),
    .wd_o(wd), .cs_o(cs_seen), .lo_o(lo), .su_o(su));
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    if (wb_ack_o !== 1'b1)
    begin
      chk(32'h0, 32'h1, "no acknowledge");
      end_of_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic run(input logic [1:0] cs, input logic w, input logic [23:0] a,
                     input logic [31:0] t);
    int n;
    wb(1'b1, ebcp_pkg::OFS_TCFG0 + {4'h0, cs, 2'b00}, t);
    wb(1'b1, ebcp_pkg::OFS_ADDR, {8'h00, a});
    wb(1'b1, ebcp_pkg::OFS_WDATA, {16'h0000, a[15:0] ^ 16'hA5A5});
    wb(1'b1, ebcp_pkg::OFS_CTRL, {23'h0, hbe_on, 2'h0, cs, 2'b00, w, 1'b1});
    n = 0;
    do
    begin
      wb(1'b0, ebcp_pkg::OFS_CTRL, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 100);
    if (n >= 100)
    begin
      chk(32'h0, 32'h1, "cycle never ended");
      end_of_test();
    end
  endtask : run
  function automatic logic [31:0] tc(input logic ab, input logic [1:0] x, input logic [1:0] c,
                                     input logic d, input logic [4:0] e, input logic [3:0] r);
    return {12'h000, r, 3'b000, e, 1'b0, d, c, x, 1'b0, ab};
  endfunction : tc
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, ebcp_pkg::OFS_RDATA, 32'hFFFF_FFFF);
    chk(q, 32'h0, "rdata written");
    wb(1'b0, ebcp_pkg::OFS_TCFG0, 32'h0);
    chk(q, ebcp_pkg::TCFG_RST, "timing reset");
    wb(1'b0, ebcp_pkg::OFS_UNIT, 32'h0);
    chk(q, {28'h0, ebcp_pkg::UNIT_RST}, "unit reset");
    wb(1'b0, ebcp_pkg::OFS_RDATA, 32'h0);
    chk(q, 32'h0, "rdata not read-only");
    wb(1'b0, 8'h3C, 32'h0);
    chk(q, 32'h0, "unmapped read");
    wb(1'b0, ebcp_pkg::OFS_STATUS, 32'h0);
    chk(q, {26'h0, ebcp_pkg::EBCP_IDLE}, "not idle");
    wb(1'b1, ebcp_pkg::OFS_UNIT, CPU - 1);
    rt = '{tc(0, 3, 3, 0, 0, 0), tc(0, 3, 0, 1, 0, 0), tc(1, 3, 0, 0, 0, 0),
           tc(0, 3, 0, 0, 31, 0), tc(0, 3, 0, 0, 0, 0)};
    ra = '{24'h12_0010, 24'h12_0020, 24'h12_0030, 24'h12_0040, 24'h34_0050};
    run(2'd1, 1'b1, 24'h12_0000, tc(0, 3, 0, 0, 0, 0));
    run(2'd1, 1'b1, 24'h12_0004, tc(0, 3, 0, 0, 0, 0));
    sub = su;
    lob = lo;
    for (int i = 0; i < 5; i++)
    begin
      run(2'd1, 1'b1, ra[i], rt[i]);
      chk(su - sub, rs[i] * CPU, "setup length");
      chk(lo - lob, rl[i] * CPU, "access length");
      chk(wd, ra[i][15:0] ^ 16'hA5A5, "write data");
      chk(cs_seen, 4'b1101, "chip select");
      chk(hbe_n, 32'h1, "high byte enable idle");
    end
    wb(1'b1, ebcp_pkg::OFS_UNIT, 32'h0);
    run(2'd2, 1'b0, 24'h56_1234, tc(0, 0, 0, 0, 0, 4'b1101));
    sub = lo;
    chk(lat, 16'h1234, "latched address");
    chk({31'h0, lo > 16'h14}, 32'h1, "ready wait");
    wb(1'b0, ebcp_pkg::OFS_RDATA, 32'h0);
    chk(q[15:0], 16'h5AC3, "muxed read data");
    rd_val <= 16'h3CA5;
    hbe_on = 1'b1;
    run(2'd3, 1'b0, 24'h56_2000, tc(0, 0, 0, 0, 0, 4'b0111));
    chk({31'h0, lo > sub}, 32'h1, "async ready stage");
    chk(cs_seen, 4'b0111, "chip select");
    chk(hbe_n, 32'h0, "high byte enable");
    wb(1'b0, ebcp_pkg::OFS_RDATA, 32'h0);
    chk(q[15:0], 16'h3CA5, "read data");
    end_of_test();
  end
endmodule : ebcp_phaser_bench
bind ebcp_phaser ebcp_phaser_properties u_ebcp_phaser_properties (.clk_i, .rst_i,
  .address_bus_o, .shared_addr_data_bus_oe_n_o, .data_bus_oe_n_o, .addr_latch_o,
  .rd_n_o, .wr_n_o, .cs_n_o, .reference_clock_out_o);
`default_nettype wire

// >>> verif/ebcp_phaser_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ebcp_phaser_properties (
  // Clock and reset
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  // External bus pins
  input wire logic [ebcp_pkg::ADDR_W-1:0] address_bus_o,
  input wire logic                        shared_addr_data_bus_oe_n_o,
  input wire logic                        data_bus_oe_n_o,
  input wire logic                        addr_latch_o,
  input wire logic                        rd_n_o,
  input wire logic                        wr_n_o,
  input wire logic [ebcp_pkg::NUM_CS-1:0] cs_n_o,
  input wire logic                        reference_clock_out_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  strobe_excl_a : assert property (rd_n_o || wr_n_o)
    else $error("both strobes low");
  strobe_cs_a : assert property (!(rd_n_o && wr_n_o) |-> !(&cs_n_o))
    else $error("strobe without chip select");
  setup_first_a : assert property ($fell(&cs_n_o) |-> rd_n_o && wr_n_o)
    else $error("strobe during address setup");
  hold_cs_a : assert property (($rose(rd_n_o) || $rose(wr_n_o)) |-> !(&cs_n_o))
    else $error("select dropped with strobe");
  one_cs_a : assert property ($onehot0(~cs_n_o))
    else $error("several selects active");
  // The address moves on the capture edge, so the read data must not depend on it.
  rd_step_a : assert property ($rose(rd_n_o) |->
    address_bus_o == $past(address_bus_o) + 24'h000001)
    else $error("address not advanced at read end");
  rd_float_a : assert property (!rd_n_o |-> data_bus_oe_n_o && shared_addr_data_bus_oe_n_o)
    else $error("data lines driven during read");
  wr_drive_a : assert property (!wr_n_o |-> !(data_bus_oe_n_o && shared_addr_data_bus_oe_n_o))
    else $error("write data not driven");
  latch_setup_a : assert property (addr_latch_o |-> rd_n_o && wr_n_o && !(&cs_n_o))
    else $error("address latch outside setup");
  refclk_toggle_a : assert property (!$past(rst_i) |->
    reference_clock_out_o != $past(reference_clock_out_o))
    else $error("reference clock not toggling");
endmodule : ebcp_phaser_properties
`default_nettype wire
